// file: par_regbank.sv
// Auto-negotiation management registers with their serial management slave.
`timescale 1ns/100ps
//
// Overview of operation
// - Identifier word two bits 15:10 hold identifier bits 19 to 24.
// - Identifier word two bits 9:4 hold a six-bit model number.
// - Identifier word two low nibble holds revision, reset per silicon revision.
// - Advertisement bit 15 is writable, resets zero; next pages are never exchanged.
// - Advertisement bits 11 and 10 are writable pause bits; bit 11 resets zero.
// - Advertised ability bits 8:5 reset from the mode straps.
// - Advertised pause bit resets from address strap bit one.
// - Selector fields hold 00001; writable locally, read-only for the partner.
// - Partner register sets acknowledge on a code word; reports next page, remote fault.
// - Partner register reports pause at bit 10 and abilities 8:5, reset zero.
// - Partner register reports T4 at bit 9; local side never claims T4.
// - Expansion bit 4 latches a parallel detection fault until read.
// - Expansion bit 1 latches high whenever a new page arrives.
// - Expansion bit 0 shows partner negotiation ability, read-only, reset zero.
// - Expansion bits 3 and 2 show partner and local next-page ability, reset zero.
// - Transmit page code field 10:0 is writable and resets to one.
// - Message-page bit 13 marks message pages; writable in transmit, resets one.
// - Bit 12 says the device will comply; writable transmit, read-only receive.
// - Toggle bit 11 is read-only and reads the inverse of the previous toggle.
// - Receive page register shows the partner page, code reset zero, message bit one.
module par_regbank import par_pkg::*; #(
	// Identifier defaults are arbitrary values.
	parameter logic [5:0] OUI_BITS = 6'h15,
	parameter logic [5:0] MODEL_NUM = 6'h2a,
	parameter logic [3:0] REV_NUM = 4'h1
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr_strap,
	input wire logic [1:0] mode_strap,
	input wire logic address_strap_bit_one,
	input wire logic lcw_valid,
	input wire logic [15:0] lcw_word,
	input wire logic np_rx_valid,
	input wire logic [15:0] np_rx_word,
	input wire logic np_tx_sent,
	input wire logic pd_fault,
	input wire logic lp_an_able,
	input wire logic lp_np_able,
	output logic [15:0] adv_word,
	output logic [15:0] np_tx_word
);
	logic mdc_s, mdio_s, mdc_d_reg, mdc_rise, mdc_fall;
	logic [7:0] strap_s;
	par_mstate_t st_reg;
	logic [5:0] ones_reg;
	logic [3:0] cnt_reg;
	logic [11:0] hdr_reg;
	logic [12:0] hdr_full;
	logic is_rd_reg, is_wr_reg, rd_req_reg, wr_req_reg;
	logic [4:0] idx_reg, phy_addr_reg;
	logic [15:0] wsh_reg, rsh_reg, wdat_reg, rd_data_reg;
	logic [2:0] strap_cnt_reg;
	logic [15:0] id2_reg, adv_reg, lpa_reg, nptx_reg, nprx_reg, exp_word;
	logic tx_toggle_reg, lpan_reg, lpnp_reg, pdf_flag, pr_flag, exp_rd;

	par_sync3 #(.WIDTH(2)) u_sync_mgmt (
		.mclk(mclk),
		.nrst(nrst),
		.din({mdc, mdio_in}),
		.dout({mdc_s, mdio_s})
	);

	par_sync3 #(.WIDTH(8)) u_sync_strap (
		.mclk(mclk),
		.nrst(nrst),
		.din({phy_addr_strap, mode_strap, address_strap_bit_one}),
		.dout(strap_s)
	);

	assign mdc_rise = mdc_s & ~mdc_d_reg;
	assign mdc_fall = ~mdc_s & mdc_d_reg;
	assign hdr_full = {hdr_reg, mdio_s};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mdc_d_reg <= 1'b0;
		end else begin
			mdc_d_reg <= mdc_s;
		end
	end

	// Serial frame receiver: preamble, header, turnaround, data.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= PAR_MS_PRE;
			ones_reg <= '0;
			cnt_reg <= '0;
			hdr_reg <= '0;
			is_rd_reg <= 1'b0;
			is_wr_reg <= 1'b0;
			idx_reg <= '0;
			wsh_reg <= '0;
			rd_req_reg <= 1'b0;
			wr_req_reg <= 1'b0;
			wdat_reg <= '0;
		end else begin
			rd_req_reg <= 1'b0;
			wr_req_reg <= 1'b0;
			if (mdc_rise) begin
				case (st_reg)
					PAR_MS_PRE: begin
						cnt_reg <= '0;
						if (mdio_s) begin
							if (ones_reg != PAR_PRE_ONES) begin
								ones_reg <= ones_reg + 6'd1;
							end
						end else if (ones_reg == PAR_PRE_ONES) begin
							st_reg <= PAR_MS_HDR;
							ones_reg <= '0;
						end else begin
							ones_reg <= '0;
						end
					end
					PAR_MS_HDR: begin
						hdr_reg <= hdr_full[11:0];
						cnt_reg <= cnt_reg + 4'd1;
						if (cnt_reg == PAR_HDR_LAST) begin
							cnt_reg <= '0;
							idx_reg <= hdr_full[4:0];
							is_rd_reg <= hdr_full[11:10] == PAR_OP_RD;
							is_wr_reg <= hdr_full[11:10] == PAR_OP_WR;
							if (hdr_full[12] && hdr_full[9:5] == phy_addr_reg &&
								(hdr_full[11:10] == PAR_OP_RD || hdr_full[11:10] == PAR_OP_WR)) begin
								st_reg <= PAR_MS_TA;
								rd_req_reg <= hdr_full[11:10] == PAR_OP_RD;
							end else begin
								st_reg <= PAR_MS_PRE;
							end
						end
					end
					PAR_MS_TA: begin
						cnt_reg <= cnt_reg + 4'd1;
						if (cnt_reg == 4'd1) begin
							st_reg <= PAR_MS_DATA;
							cnt_reg <= '0;
						end
					end
					PAR_MS_DATA: begin
						wsh_reg <= {wsh_reg[14:0], mdio_s};
						cnt_reg <= cnt_reg + 4'd1;
						if (cnt_reg == PAR_DATA_LAST) begin
							st_reg <= PAR_MS_PRE;
							cnt_reg <= '0;
							wr_req_reg <= is_wr_reg;
							wdat_reg <= {wsh_reg[14:0], mdio_s};
						end
					end
					default: begin
						st_reg <= PAR_MS_PRE;
						ones_reg <= '0;
					end
				endcase
			end
		end
	end

	// Read data drive: zero in the second turnaround bit, then data most significant first.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			rsh_reg <= '0;
		end else begin
			if (rd_req_reg) begin
				rsh_reg <= '0;
			end else if (st_reg == PAR_MS_TA && cnt_reg == 4'd0 && is_rd_reg) begin
				rsh_reg <= rd_data_reg;
			end
			if (mdc_fall) begin
				if (st_reg == PAR_MS_TA && cnt_reg == 4'd1 && is_rd_reg) begin
					mdio_oe <= 1'b1;
					mdio_out <= 1'b0;
				end else if (st_reg == PAR_MS_DATA && is_rd_reg) begin
					mdio_oe <= 1'b1;
					mdio_out <= rsh_reg[15];
					rsh_reg <= {rsh_reg[14:0], 1'b0};
				end else if (st_reg != PAR_MS_TA) begin
					mdio_oe <= 1'b0;
					mdio_out <= 1'b0;
				end
			end
		end
	end

	// Straps are taken once the synchronisers have settled after reset.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_reg <= '0;
			phy_addr_reg <= '0;
		end else if (strap_cnt_reg != PAR_STRAP_WAIT) begin
			strap_cnt_reg <= strap_cnt_reg + 3'd1;
			phy_addr_reg <= strap_s[7:3];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			id2_reg <= {OUI_BITS, MODEL_NUM, REV_NUM};
		end else if (wr_req_reg && idx_reg == PAR_IDX_ID2) begin
			id2_reg <= wdat_reg;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			adv_reg <= PAR_ADV_RST;
		end else if (strap_cnt_reg != PAR_STRAP_WAIT) begin
			adv_reg[PAR_B_ABIL_HI:PAR_B_ABIL_LO] <= par_strap_abil(strap_s[2:1]);
			adv_reg[PAR_B_PAUSE] <= strap_s[0];
		end else if (wr_req_reg && idx_reg == PAR_IDX_ADV) begin
			adv_reg <= wdat_reg & PAR_ADV_WMASK;
		end
	end

	// The engine never sees the next-page request, so next pages are not exchanged.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			adv_word <= PAR_ADV_RST;
		end else begin
			adv_word <= adv_reg & ~(16'h0001 << PAR_B_NP);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lpa_reg <= PAR_LPA_RST;
		end else if (lcw_valid) begin
			lpa_reg[PAR_B_NP] <= lcw_word[PAR_B_NP];
			lpa_reg[PAR_B_ACK] <= 1'b1;
			lpa_reg[PAR_B_RF] <= lcw_word[PAR_B_RF];
			lpa_reg[PAR_B_PAUSE] <= lcw_word[PAR_B_PAUSE];
			lpa_reg[PAR_B_T4] <= lcw_word[PAR_B_T4];
			lpa_reg[PAR_B_ABIL_HI:PAR_B_ABIL_LO] <= lcw_word[PAR_B_ABIL_HI:PAR_B_ABIL_LO];
			lpa_reg[PAR_B_SEL_HI:0] <= PAR_SELECTOR;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lpan_reg <= 1'b0;
			lpnp_reg <= 1'b0;
		end else begin
			lpan_reg <= lp_an_able;
			lpnp_reg <= lp_np_able;
		end
	end

	assign exp_rd = rd_req_reg && idx_reg == PAR_IDX_EXP;

	par_lh_bit u_pdf (
		.mclk(mclk),
		.nrst(nrst),
		.set_evt(pd_fault),
		.rd_clr(exp_rd),
		.flag(pdf_flag)
	);

	par_lh_bit u_pr (
		.mclk(mclk),
		.nrst(nrst),
		.set_evt(lcw_valid | np_rx_valid),
		.rd_clr(exp_rd),
		.flag(pr_flag)
	);

	always_comb begin
		exp_word = '0;
		exp_word[PAR_E_PDF] = pdf_flag;
		exp_word[PAR_E_LPNP] = lpnp_reg;
		exp_word[PAR_E_NP] = 1'b0;
		exp_word[PAR_E_PR] = pr_flag;
		exp_word[PAR_E_LPAN] = lpan_reg;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nptx_reg <= PAR_NPTX_RST;
		end else if (wr_req_reg && idx_reg == PAR_IDX_NPTX) begin
			nptx_reg <= wdat_reg & PAR_NPTX_WMASK;
		end
	end

	// The toggle flips each time a transmit page leaves.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tx_toggle_reg <= 1'b0;
		end else if (np_tx_sent) begin
			tx_toggle_reg <= ~tx_toggle_reg;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			np_tx_word <= PAR_NPTX_RST;
		end else begin
			np_tx_word <= nptx_reg | ({15'h0000, tx_toggle_reg} << PAR_B_TOGGLE);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nprx_reg <= PAR_NPRX_RST;
		end else if (np_rx_valid) begin
			nprx_reg <= np_rx_word;
		end
	end

	// Read data are snapshotted as the read header completes.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_data_reg <= '0;
		end else if (rd_req_reg) begin
			case (idx_reg)
				PAR_IDX_ID2: rd_data_reg <= id2_reg;
				PAR_IDX_ADV: rd_data_reg <= adv_reg;
				PAR_IDX_LPA: rd_data_reg <= lpa_reg;
				PAR_IDX_EXP: rd_data_reg <= exp_word;
				PAR_IDX_NPTX: rd_data_reg <= np_tx_word;
				PAR_IDX_NPRX: rd_data_reg <= nprx_reg;
				default: rd_data_reg <= '0;
			endcase
		end
	end
endmodule : par_regbank

// file: par_pkg.sv
// Package of constants for the auto-negotiation management register bank.
package par_pkg;
	// Register indices on the management bus.
	localparam logic [4:0] PAR_IDX_ID2 = 5'h03;
	localparam logic [4:0] PAR_IDX_ADV = 5'h04;
	localparam logic [4:0] PAR_IDX_LPA = 5'h05;
	localparam logic [4:0] PAR_IDX_EXP = 5'h06;
	localparam logic [4:0] PAR_IDX_NPTX = 5'h07;
	localparam logic [4:0] PAR_IDX_NPRX = 5'h08;
	// Field positions.
	localparam int PAR_ID_OUI_HI = 15;
	localparam int PAR_ID_OUI_LO = 10;
	localparam int PAR_ID_MODEL_HI = 9;
	localparam int PAR_ID_MODEL_LO = 4;
	localparam int PAR_ID_REV_HI = 3;
	localparam int PAR_B_NP = 15;
	localparam int PAR_B_ACK = 14;
	localparam int PAR_B_RF = 13;
	localparam int PAR_B_MP = 13;
	localparam int PAR_B_ACK2 = 12;
	localparam int PAR_B_ASYM = 11;
	localparam int PAR_B_TOGGLE = 11;
	localparam int PAR_B_PAUSE = 10;
	localparam int PAR_B_T4 = 9;
	localparam int PAR_B_ABIL_HI = 8;
	localparam int PAR_B_ABIL_LO = 5;
	localparam int PAR_B_SEL_HI = 4;
	localparam int PAR_B_CODE_HI = 10;
	localparam int PAR_E_PDF = 4;
	localparam int PAR_E_LPNP = 3;
	localparam int PAR_E_NP = 2;
	localparam int PAR_E_PR = 1;
	localparam int PAR_E_LPAN = 0;
	// Reset values and writable masks.
	localparam logic [4:0] PAR_SELECTOR = 5'h01;
	localparam logic [15:0] PAR_ADV_RST = 16'h0001;
	localparam logic [15:0] PAR_ADV_WMASK = 16'hade0 | 16'h001f;
	localparam logic [15:0] PAR_LPA_RST = 16'h0001;
	localparam logic [15:0] PAR_NPTX_RST = 16'h2001;
	localparam logic [15:0] PAR_NPTX_WMASK = 16'hb7ff;
	localparam logic [15:0] PAR_NPRX_RST = 16'h2000;
	// Ability sets selected by the mode straps: 100 full, 100, 10 full, 10.
	localparam logic [3:0] PAR_ABIL_M0 = 4'h3;
	localparam logic [3:0] PAR_ABIL_M1 = 4'hc;
	localparam logic [3:0] PAR_ABIL_M2 = 4'hf;
	localparam logic [3:0] PAR_ABIL_M3 = 4'hf;
	// Management frame figures.
	localparam logic [5:0] PAR_PRE_ONES = 6'd32;
	localparam logic [3:0] PAR_HDR_LAST = 4'd12;
	localparam logic [3:0] PAR_DATA_LAST = 4'd15;
	localparam logic [1:0] PAR_OP_RD = 2'b10;
	localparam logic [1:0] PAR_OP_WR = 2'b01;
	localparam logic [2:0] PAR_STRAP_WAIT = 3'd6;

	typedef enum logic [3:0] {
		PAR_MS_PRE = 4'b0001,
		PAR_MS_HDR = 4'b0010,
		PAR_MS_TA = 4'b0100,
		PAR_MS_DATA = 4'b1000
	} par_mstate_t;

	// Maps the mode straps onto the advertised ability bits.
	function automatic logic [3:0] par_strap_abil(input logic [1:0] mode);
		case (mode)
			2'b00: par_strap_abil = PAR_ABIL_M0;
			2'b01: par_strap_abil = PAR_ABIL_M1;
			2'b10: par_strap_abil = PAR_ABIL_M2;
			default: par_strap_abil = PAR_ABIL_M3;
		endcase
	endfunction : par_strap_abil
endpackage : par_pkg

// file: par_sync3.sv
// Three-flop input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module par_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dout <= '0;
		end else if (s2_reg == s3_reg) begin
			dout <= s3_reg;
		end
	end
endmodule : par_sync3

// file: par_lh_bit.sv
// Latch-high status flag that holds an event until the register is read.
`timescale 1ns/100ps
module par_lh_bit (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic set_evt,
	input wire logic rd_clr,
	output logic flag
);
	// A set in the same cycle as the read clear wins.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flag <= 1'b0;
		end else begin
			flag <= set_evt | (flag & ~rd_clr);
		end
	end
endmodule : par_lh_bit

// file: par_regbank_monitor.sv
// Concurrent checks on the ports of the auto-negotiation register bank.
`timescale 1ns/100ps
module par_regbank_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic np_tx_sent,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic [15:0] adv_word,
	input wire logic [15:0] np_tx_word
);
	logic [9:0] oe_cnt;

	// Counts the cycles the device has driven the management pin.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			oe_cnt <= 10'h000;
		end else begin
			oe_cnt <= mdio_oe ? oe_cnt + 10'h001 : 10'h000;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence tog_chg_s;
		##[1:2] $changed(np_tx_word[11]);
	endsequence
	sequence oe_end_s;
		$fell(mdio_oe) ##0 (oe_cnt >= 10'h10e && oe_cnt <= 10'h112);
	endsequence

	adv_np_zero_a: assert property (adv_word[15] == 1'b0)
		else $error("advertised next page bit set");
	adv_rsv_a: assert property (adv_word[14] == 1'b0 && adv_word[12] == 1'b0 && adv_word[9] == 1'b0)
		else $error("reserved or T4 advertisement bit set");
	nptx_rsv_a: assert property (np_tx_word[14] == 1'b0)
		else $error("reserved transmit page bit set");
	toggle_flip_a: assert property (np_tx_sent |-> tog_chg_s)
		else $error("toggle did not flip after a sent page");
	toggle_hold_a: assert property ($changed(np_tx_word[11]) |-> $past(np_tx_sent) || $past(np_tx_sent, 2))
		else $error("toggle changed without a sent page");
	reset_vals_a: assert property ($rose(nrst) |-> $past(adv_word) == 16'h0001 && $past(np_tx_word) == 16'h2001)
		else $error("wrong word during reset");
	oe_start_a: assert property ($rose(mdio_oe) |-> mdio_out == 1'b0)
		else $error("turnaround bit not zero");
	oe_span_a: assert property ($fell(mdio_oe) |-> oe_end_s)
		else $error("read drive span wrong");
endmodule : par_regbank_monitor

// file: par_mdio_host.sv
// Station management host model that clocks frames on the management pins.
`timescale 1ns/100ps
module par_mdio_host import par_pkg::*; (
	input wire logic mclk,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_in
);
	logic drv_en;
	logic drv_val;

	// A released line floats up through the pull-up.
	assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b1;
	end

	// One frame: 32 ones, start, op, addresses, turnaround, 16 data bits, then an idle bit.
	task xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] bits;
		int i;
		bits = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		for (i = 64; i >= 0; i--) begin
			@(negedge mclk);
			mdc = 1'b0;
			drv_en = (i > 0) && !(op == PAR_OP_RD && i <= 18);
			drv_val = bits[63];
			bits = bits << 1;
			repeat (8) @(negedge mclk);
			if (i > 0 && i <= 16) begin
				rd = {rd[14:0], mdio_in};
			end
			mdc = 1'b1;
			repeat (7) @(negedge mclk);
		end
	endtask : xfer
endmodule : par_mdio_host

// file: testbench.sv
// Testbench for the auto-negotiation register bank.
`timescale 1ns/100ps
module testbench import par_pkg::*;;
	localparam logic [4:0] ADDR = 5'h05;
	logic mclk, nrst, mdc, mdio_in, mdio_out, mdio_oe;
	logic lcw_valid, np_rx_valid, np_tx_sent, pd_fault, lp_an_able, lp_np_able, pause_strap;
	logic [1:0] mode_sel;
	logic [15:0] lcw_word, np_rx_word, adv_word, np_tx_word, rd;
	int failures, comparisons;

	par_regbank dut (
		.mclk(mclk),
		.nrst(nrst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.phy_addr_strap(ADDR),
		.mode_strap(mode_sel),
		.address_strap_bit_one(pause_strap),
		.lcw_valid(lcw_valid),
		.lcw_word(lcw_word),
		.np_rx_valid(np_rx_valid),
		.np_rx_word(np_rx_word),
		.np_tx_sent(np_tx_sent),
		.pd_fault(pd_fault),
		.lp_an_able(lp_an_able),
		.lp_np_able(lp_np_able),
		.adv_word(adv_word),
		.np_tx_word(np_tx_word)
	);

	par_mdio_host host (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task rd_chk(input logic [4:0] ra, input logic [15:0] exp);
		host.xfer(PAR_OP_RD, ADDR, ra, 16'h0000, rd);
		chk($sformatf("register %h", ra), exp, rd);
	endtask : rd_chk

	task wr(input logic [4:0] ra, input logic [15:0] wd);
		host.xfer(PAR_OP_WR, ADDR, ra, wd, rd);
	endtask : wr

	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask : pulse

	task finish_test;
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		#6000000;
		failures++;
		finish_test();
	end

	initial begin
		failures = 0;
		comparisons = 0;
		nrst = 1'b0;
		{lcw_valid, np_rx_valid, np_tx_sent, pd_fault, lp_an_able, lp_np_able} = 6'h00;
		lcw_word = 16'h0000;
		np_rx_word = 16'h0000;
		mode_sel = 2'b01;
		pause_strap = 1'b1;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		repeat (10) @(negedge mclk);
		rd_chk(PAR_IDX_ID2, {6'h15, 6'h2a, 4'h1});
		rd_chk(PAR_IDX_ADV, 16'h0581);
		rd_chk(PAR_IDX_LPA, 16'h0001);
		rd_chk(PAR_IDX_EXP, 16'h0000);
		rd_chk(PAR_IDX_NPTX, 16'h2001);
		rd_chk(PAR_IDX_NPRX, 16'h2000);
		rd_chk(5'h09, 16'h0000);
		host.xfer(PAR_OP_RD, 5'h06, PAR_IDX_ID2, 16'h0000, rd);
		chk("foreign address", 16'hffff, rd);
		$display("Test reset values done");
		wr(PAR_IDX_ADV, 16'hffff);
		rd_chk(PAR_IDX_ADV, 16'hadff);
		chk("adv_word", 16'h2dff, adv_word);
		wr(PAR_IDX_ADV, 16'h0000);
		rd_chk(PAR_IDX_ADV, 16'h0000);
		wr(PAR_IDX_NPTX, 16'hffff);
		rd_chk(PAR_IDX_NPTX, 16'hb7ff);
		chk("np_tx_word", 16'hb7ff, np_tx_word);
		pulse(np_tx_sent);
		rd_chk(PAR_IDX_NPTX, 16'hbfff);
		wr(PAR_IDX_LPA, 16'h0000);
		wr(PAR_IDX_NPRX, 16'hffff);
		wr(PAR_IDX_EXP, 16'hffff);
		rd_chk(PAR_IDX_LPA, 16'h0001);
		rd_chk(PAR_IDX_NPRX, 16'h2000);
		rd_chk(PAR_IDX_EXP, 16'h0000);
		$display("Test register writes done");
		lcw_word = 16'hffff;
		lp_an_able = 1'b1;
		lp_np_able = 1'b1;
		pulse(lcw_valid);
		pulse(pd_fault);
		rd_chk(PAR_IDX_LPA, 16'he7e1);
		rd_chk(PAR_IDX_EXP, 16'h001b);
		rd_chk(PAR_IDX_EXP, 16'h0009);
		np_rx_word = 16'h5a5a;
		pulse(np_rx_valid);
		rd_chk(PAR_IDX_NPRX, 16'h5a5a);
		rd_chk(PAR_IDX_EXP, 16'h000b);
		lcw_word = 16'h0000;
		pulse(lcw_valid);
		rd_chk(PAR_IDX_LPA, 16'h4001);
		$display("Test partner events done");
		@(negedge mclk);
		nrst = 1'b0;
		mode_sel = 2'b10;
		pause_strap = 1'b0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		repeat (10) @(negedge mclk);
		rd_chk(PAR_IDX_ADV, 16'h01e1);
		rd_chk(PAR_IDX_EXP, 16'h0009);
		rd_chk(PAR_IDX_LPA, 16'h0001);
		rd_chk(PAR_IDX_NPTX, 16'h2001);
		rd_chk(PAR_IDX_NPRX, 16'h2000);
		$display("Test mid-run reset done");
		finish_test();
	end
endmodule : testbench

bind par_regbank par_regbank_monitor mon (
	.mclk(mclk),
	.nrst(nrst),
	.np_tx_sent(np_tx_sent),
	.mdio_out(mdio_out),
	.mdio_oe(mdio_oe),
	.adv_word(adv_word),
	.np_tx_word(np_tx_word)
);
